// >>> src/usb_bridge_power_config.sv
// Device end: strap capture, power registers, suspend and clock-run request
//
// Contract
// R01 - Strap low selects 5V, high 3.3V
// R02 - Register bit 5 of 52h overrides strap
// R03 - Over-current polarity follows its own strap
// R04 - Each fault input maps to its port
// R05 - Bit 2 of 50h enables clock-run
// R06 - Bit 4 of 50h selects power-saving mode
// R07 - Host writes 11 to 04h[7:6] first
// R08 - USB clock stops only after suspend
// R09 - Wake events request clock-run when enabled
// R10 - 50h[1:0]=11 switches USB I/O off
// R11 - Firmware disables I/O before suspend
// R12 - Stopped PCI clock tolerated and resumed
// R13 - Clock-run is sustained tristate handshake
// R14 - Straps latched during reset, held after; here sampled on the first edge after reset releases
//
// Chosen here: the strobed register port.
`timescale 1ns/100ps
module usb_bridge_power_config
	import pwr_cfg_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst,
	// Straps and fault pins
	input  wire logic        voltage_select_strap,
	input  wire logic        port1_overcurrent_in,
	input  wire logic        port2_overcurrent_in,
	// USB wake events and clock state
	input  wire logic        usb_resume,
	input  wire logic        usb_connect,
	input  wire logic        usb_disconnect,
	input  wire logic        usb_clk_stopped,
	// Register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	// Status outputs
	output logic             core_5v,
	output logic             port1_fault,
	output logic             port2_fault,
	output logic             usb_suspended,
	output logic             usb_io_off,
	output logic             irq,
	// Clock-run link
	clkrun_if.device         link
);
	import pwr_cfg_pkg::*;

	typedef enum logic [1:0] {cr_idle, cr_wait, cr_assert} cr_state_type;

	logic        strap_volt_q, strap_volt_d;
	logic        strap_oc1_q, strap_oc1_d;
	logic        strap_oc2_q, strap_oc2_d;
	logic        ovr_valid_q, ovr_valid_d;
	logic        ovr_5v_q, ovr_5v_d;
	logic [31:0] hcc_q, hcc_d;
	logic [7:0]  pcc_q, pcc_d;
	logic [4:0]  status_q, status_d;
	logic [4:0]  mask_q, mask_d;
	logic [31:0] rdata_q, rdata_d;
	logic        core_5v_q, core_5v_d;
	logic        f1_q, f1_d;
	logic        f2_q, f2_d;
	logic        susp_q, susp_d;
	logic        iooff_q, iooff_d;
	logic        irq_q, irq_d;
	logic        latch_q, latch_d;
	cr_state_type cr_q, cr_d;
	logic [3:0]  cr_cnt_q, cr_cnt_d;
	logic        cr_drive_q, cr_drive_d;
	logic        wake_pend_q, wake_pend_d;
	logic        wake_ev;
	logic [4:0]  ev;

	assign wake_ev = usb_resume | usb_connect | usb_disconnect;

	// Next-state for straps, registers, status and outputs
	always_comb
	begin
		strap_volt_d = strap_volt_q;
		strap_oc1_d  = strap_oc1_q;
		strap_oc2_d  = strap_oc2_q;
		latch_d      = 1'b0;
		ovr_valid_d  = ovr_valid_q;
		ovr_5v_d     = ovr_5v_q;
		hcc_d        = hcc_q;
		pcc_d        = pcc_q;
		mask_d       = mask_q;
		rdata_d      = 32'h0000_0000;
		// Straps are sampled on the first edge after release and then frozen
		if (latch_q)
		begin
			strap_volt_d = voltage_select_strap; // R14
			strap_oc1_d  = port1_overcurrent_in; // R14
			strap_oc2_d  = port2_overcurrent_in; // R14
		end
		if (reg_wr)
		begin
			unique case (reg_addr)
				host_controller_control_off: hcc_d = reg_wdata; // R07
				power_clock_control_off: pcc_d = reg_wdata[7:0];
				core_voltage_select_off:
				begin
					ovr_valid_d = 1'b1; // R02
					ovr_5v_d    = reg_wdata[volt_5v_bit]; // R02
				end
				irq_mask_off: mask_d = reg_wdata[4:0];
				default: ;
			endcase
		end
		if (reg_rd)
		begin
			unique case (reg_addr)
				host_controller_control_off: rdata_d = hcc_q;
				power_clock_control_off: rdata_d = {24'h000000, pcc_q};
				core_voltage_select_off: rdata_d = {26'h0000000, core_5v_q, 5'h00};
				irq_status_off: rdata_d = {27'h0000000, status_q};
				irq_mask_off: rdata_d = {27'h0000000, mask_q};
				state_off: rdata_d = {25'h0000000, usb_clk_stopped, strap_volt_q, strap_oc2_q,
					strap_oc1_q, iooff_q, susp_q, cr_drive_q};
				default: rdata_d = 32'h0000_0000;
			endcase
		end
		// Next strap values, so the latch cycle shows no false fault edge
		core_5v_d = ovr_valid_q ? ovr_5v_q : ~strap_volt_d; // R01 R02
		// Strap low means active high, strap high means active low
		f1_d      = port1_overcurrent_in ^ strap_oc1_d; // R03 R04
		f2_d      = port2_overcurrent_in ^ strap_oc2_d; // R03 R04
		susp_d    = (hcc_q[susp_hi_bit:susp_lo_bit] == usb_suspend_code);
		iooff_d   = (pcc_q[io_off_hi_bit:io_off_lo_bit] == io_off_code); // R10
		// Events; set beats the read-clear in the same cycle
		ev[ev_wake_bit] = wake_ev;
		ev[ev_oc1_bit]  = f1_d & ~f1_q;
		ev[ev_oc2_bit]  = f2_d & ~f2_q;
		ev[ev_clk_bit]  = cr_drive_d & ~cr_drive_q;
		ev[ev_volt_bit] = ~latch_q & (core_5v_d ^ core_5v_q); // No event for the strap load
		status_d = status_q;
		if (reg_rd && reg_addr == irq_status_off)
			status_d = 5'h00;
		status_d = status_d | ev;
		irq_d = |(status_q & mask_q);
	end

	// Clock-run: request the PCI clock on wake, or hold it while still busy
	always_comb
	begin
		cr_d        = cr_q;
		cr_cnt_d    = cr_cnt_q;
		cr_drive_d  = 1'b0;
		wake_pend_d = wake_pend_q;
		if (pcc_q[clkrun_en_bit] && wake_ev)
			wake_pend_d = 1'b1; // R09
		unique case (cr_q)
			cr_idle:
				// Wake works even with the USB clock stopped: it is a plain level here
				// A busy device claims the line before the host can stop the clock
				if (pcc_q[clkrun_en_bit] && (wake_pend_q || (link.clkrun_n &&
					(!pcc_q[clkrun_save_bit] || !susp_q) && link.pci_clk_run)))
				begin
					cr_d     = cr_wait; // R05 R06 R12
					cr_cnt_d = clkrun_stop_cycles;
				end
			cr_wait:
				// Only pull low while host released the line (stop request)
				if (link.clkrun_n)
					cr_d = cr_assert; // R13
				else
					cr_d = cr_idle;
			cr_assert:
			begin
				cr_drive_d = 1'b1; // R09 R13
				if (cr_cnt_q != 4'h0)
					cr_cnt_d = cr_cnt_q - 4'h1;
				else
				begin
					cr_d        = cr_idle;
					wake_pend_d = 1'b0;
				end
			end
		endcase
	end

	// Registers; straps latch once reset releases
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			strap_volt_q <= 1'b0;
			strap_oc1_q  <= 1'b0;
			strap_oc2_q  <= 1'b0;
			latch_q      <= 1'b1;
			ovr_valid_q  <= 1'b0;
			ovr_5v_q     <= 1'b0;
			hcc_q        <= host_controller_control_rst;
			pcc_q        <= power_clock_control_rst;
			status_q     <= 5'h00;
			mask_q       <= irq_mask_rst;
			rdata_q      <= 32'h0000_0000;
			core_5v_q    <= 1'b1;
			f1_q         <= 1'b0;
			f2_q         <= 1'b0;
			susp_q       <= 1'b0;
			iooff_q      <= 1'b0;
			irq_q        <= 1'b0;
			cr_q         <= cr_idle;
			cr_cnt_q     <= 4'h0;
			cr_drive_q   <= 1'b0;
			wake_pend_q  <= 1'b0;
		end
		else
		begin
			strap_volt_q <= strap_volt_d;
			strap_oc1_q  <= strap_oc1_d;
			strap_oc2_q  <= strap_oc2_d;
			latch_q      <= latch_d;
			ovr_valid_q  <= ovr_valid_d;
			ovr_5v_q     <= ovr_5v_d;
			hcc_q        <= hcc_d;
			pcc_q        <= pcc_d;
			status_q     <= status_d;
			mask_q       <= mask_d;
			rdata_q      <= rdata_d;
			core_5v_q    <= core_5v_d;
			f1_q         <= f1_d;
			f2_q         <= f2_d;
			susp_q       <= susp_d;
			iooff_q      <= iooff_d;
			irq_q        <= irq_d;
			cr_q         <= cr_d;
			cr_cnt_q     <= cr_cnt_d;
			cr_drive_q   <= cr_drive_d;
			wake_pend_q  <= wake_pend_d;
		end
	end

	// Outputs straight from flops; pin only ever driven low
	assign reg_rdata         = rdata_q;
	assign core_5v           = core_5v_q;
	assign port1_fault       = f1_q;
	assign port2_fault       = f2_q;
	assign usb_suspended     = susp_q;
	assign usb_io_off        = iooff_q;
	assign irq               = irq_q;
	assign link.dev_clkrun_o  = 1'b0;
	assign link.dev_clkrun_oe = cr_drive_q;
endmodule

// >>> src/pwr_cfg_pkg.sv
// Package: register map, field positions, reset values and clock-run timing
package pwr_cfg_pkg;
	// Register offsets on the configuration and memory port
	localparam logic [7:0] host_controller_control_off = 8'h04;
	localparam logic [7:0] power_clock_control_off     = 8'h50;
	localparam logic [7:0] core_voltage_select_off     = 8'h52;
	localparam logic [7:0] irq_status_off              = 8'h60;
	localparam logic [7:0] irq_mask_off                = 8'h64;
	localparam logic [7:0] state_off                   = 8'h68;
	// Field positions
	localparam int io_off_lo_bit      = 0;
	localparam int io_off_hi_bit      = 1;
	localparam int clkrun_en_bit      = 2;
	localparam int clkrun_save_bit    = 4;
	localparam int volt_5v_bit        = 5;
	localparam int susp_lo_bit        = 6;
	localparam int susp_hi_bit        = 7;
	localparam logic [1:0] usb_suspend_code = 2'h3;
	localparam logic [1:0] io_off_code      = 2'h3;
	// Reset values
	localparam logic [31:0] host_controller_control_rst = 32'h0000_0000;
	localparam logic [7:0]  power_clock_control_rst     = 8'h00;
	localparam logic [4:0]  irq_mask_rst                = 5'h00;
	// Interrupt status bit positions
	localparam int ev_wake_bit  = 0;
	localparam int ev_oc1_bit   = 1;
	localparam int ev_oc2_bit   = 2;
	localparam int ev_clk_bit   = 3;
	localparam int ev_volt_bit  = 4;
	// Clock-run timing in system clocks
	localparam logic [3:0] clkrun_idle_cycles = 4'h8;
	localparam logic [3:0] clkrun_stop_cycles = 4'h4;
endpackage

// >>> src/clkrun_if.sv
// Interface: clock-run wire and clock gating between device and host chipset
`timescale 1ns/100ps
interface clkrun_if;
	logic dev_clkrun_o;
	logic dev_clkrun_oe;
	logic host_clkrun_o;
	logic host_clkrun_oe;
	logic pci_clk_run;
	logic clkrun_n;
	// Sustained tristate wire with pull-up: low if either end drives low
	assign clkrun_n = ~((dev_clkrun_oe & ~dev_clkrun_o) | (host_clkrun_oe & ~host_clkrun_o));
	modport device (output dev_clkrun_o, output dev_clkrun_oe, input clkrun_n,
		input pci_clk_run);
	modport host (output host_clkrun_o, output host_clkrun_oe, input clkrun_n,
		output pci_clk_run);
endinterface

// >>> src/clkrun_host.sv
// Host end: chipset clock-run master that stops and restarts the PCI clock
`timescale 1ns/100ps
module clkrun_host
	import pwr_cfg_pkg::*;
(
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic rst,
	// User side
	input  wire logic stop_allowed,
	output logic      pci_clk_on,
	output logic      clk_restarted,
	// Clock-run link
	clkrun_if.host    link
);
	import pwr_cfg_pkg::*;

	typedef enum logic [1:0] {h_run, h_release, h_stopped, h_restart} h_state_type;

	h_state_type st_q, st_d;
	logic [3:0]  cnt_q, cnt_d;
	logic        run_q, run_d;
	logic        drv_q, drv_d;
	logic        rst_ev_q, rst_ev_d;

	// Idle long enough, release line; if nobody holds it low, stop the clock
	always_comb
	begin
		st_d     = st_q;
		cnt_d    = cnt_q;
		run_d    = run_q;
		drv_d    = drv_q;
		rst_ev_d = 1'b0;
		unique case (st_q)
			h_run:
				if (stop_allowed && cnt_q == clkrun_idle_cycles)
				begin
					st_d  = h_release; // R13
					drv_d = 1'b0;
					cnt_d = 4'h0;
				end
				else if (stop_allowed)
					cnt_d = cnt_q + 4'h1;
				else
					cnt_d = 4'h0;
			h_release:
				if (!link.clkrun_n)
				begin
					st_d  = h_run; // R13
					drv_d = 1'b1;
				end
				else if (cnt_q == clkrun_stop_cycles)
				begin
					st_d  = h_stopped; // R12
					run_d = 1'b0;
				end
				else
					cnt_d = cnt_q + 4'h1;
			h_stopped:
				if (!link.clkrun_n || !stop_allowed)
				begin
					st_d  = h_restart; // R12
					run_d = 1'b1;
					drv_d = 1'b1;
				end
			h_restart:
			begin
				st_d     = h_run;
				cnt_d    = 4'h0;
				rst_ev_d = 1'b1;
			end
		endcase
	end

	// State registers
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			st_q     <= h_run;
			cnt_q    <= 4'h0;
			run_q    <= 1'b1;
			drv_q    <= 1'b1;
			rst_ev_q <= 1'b0;
		end
		else
		begin
			st_q     <= st_d;
			cnt_q    <= cnt_d;
			run_q    <= run_d;
			drv_q    <= drv_d;
			rst_ev_q <= rst_ev_d;
		end
	end

	assign pci_clk_on          = run_q;
	assign clk_restarted       = rst_ev_q;
	assign link.pci_clk_run    = run_q;
	assign link.host_clkrun_o  = 1'b0;
	assign link.host_clkrun_oe = drv_q;
endmodule

// >>> tb/usb_bridge_power_config_checker.sv
// Checker: clock-run wire handshake between device and host ends
`timescale 1ns/100ps
module usb_bridge_power_config_checker (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic dev_clkrun_o,
	input wire logic dev_clkrun_oe,
	input wire logic host_clkrun_o,
	input wire logic host_clkrun_oe,
	input wire logic pci_clk_run,
	input wire logic clkrun_n
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	// Clock stopped and line pulled low by the device
	sequence s_wake; !pci_clk_run && !clkrun_n; endsequence
	// Host brings the clock back and drives again
	sequence s_back; ##[1:2] (pci_clk_run && host_clkrun_oe); endsequence
	// Ends may only pull low, never drive high
	property p_dev_low; dev_clkrun_oe |-> !dev_clkrun_o && !clkrun_n; endproperty
	property p_host_low; host_clkrun_oe |-> !host_clkrun_o && !clkrun_n; endproperty
	property p_dev_hold; $rose(dev_clkrun_oe) |-> dev_clkrun_oe[*5]; endproperty
	property p_dev_quiet; $rose(dev_clkrun_oe) |-> !host_clkrun_oe; endproperty
	property p_restart; s_wake |-> s_back; endproperty
	property p_stop_quiet; !pci_clk_run |-> !host_clkrun_oe; endproperty
	property p_rise_drive; $rose(pci_clk_run) |-> host_clkrun_oe; endproperty
	// Clock only stops after the line idled high while released
	property p_stop_cause;
		$fell(pci_clk_run) |-> $past(clkrun_n) && !$past(host_clkrun_oe, 3);
	endproperty
	a_dev_low: assert property (p_dev_low) else $error("device drove line high");
	a_host_low: assert property (p_host_low) else $error("host drove line high");
	a_dev_hold: assert property (p_dev_hold) else $error("device pull too short");
	a_dev_quiet: assert property (p_dev_quiet) else $error("device pulled early");
	a_restart: assert property (p_restart) else $error("clock not restarted");
	a_stop_quiet: assert property (p_stop_quiet) else $error("host drove while stopped");
	a_rise_drive: assert property (p_rise_drive) else $error("restart without drive");
	a_stop_cause: assert property (p_stop_cause) else $error("clock stopped early");
endmodule

// >>> tb/usb_bridge_power_config_tb.sv
// Testbench: register port, faults, interrupts and clock-run across both ends
`timescale 1ns/100ps
module usb_bridge_power_config_tb;
	import pwr_cfg_pkg::*;
	logic        clk_sys, rst, voltage_select_strap, stop_allowed;
	logic        port1_overcurrent_in, port2_overcurrent_in, reg_wr, reg_rd;
	logic        core_5v, port1_fault, port2_fault, usb_suspended, usb_io_off, irq;
	logic        pci_clk_on, usb_clk_stopped, clk_restarted;
	logic [2:0]  wake;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata, d;
	int          n_errors, samples_checked, k;
	clkrun_if link_if();
	usb_bridge_power_config usb_bridge_power_config_i (.clk_sys(clk_sys), .rst(rst),
		.voltage_select_strap(voltage_select_strap), .port1_overcurrent_in(port1_overcurrent_in),
		.port2_overcurrent_in(port2_overcurrent_in), .usb_resume(wake[0]),
		.usb_connect(wake[1]), .usb_disconnect(wake[2]), .usb_clk_stopped(usb_clk_stopped),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .core_5v(core_5v), .port1_fault(port1_fault),
		.port2_fault(port2_fault), .usb_suspended(usb_suspended), .usb_io_off(usb_io_off),
		.irq(irq), .link(link_if));
	clkrun_host clkrun_host_i (.clk_sys(clk_sys), .rst(rst), .stop_allowed(stop_allowed),
		.pci_clk_on(pci_clk_on), .clk_restarted(clk_restarted), .link(link_if));
	usb_bridge_power_config_checker usb_bridge_power_config_checker_i (.clk_sys(clk_sys),
		.rst(rst), .dev_clkrun_o(link_if.dev_clkrun_o), .dev_clkrun_oe(link_if.dev_clkrun_oe),
		.host_clkrun_o(link_if.host_clkrun_o), .host_clkrun_oe(link_if.host_clkrun_oe),
		.pci_clk_run(link_if.pci_clk_run), .clkrun_n(link_if.clkrun_n));
	// 25 MHz system clock
	always #20 clk_sys = ~clk_sys;
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	// Data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
		@(posedge clk_sys);
	endtask
	// Bounded wait for the PCI clock state
	task automatic await_clk(input logic v);
		for (int i = 0; i < 60 && pci_clk_on !== v; i++)
			@(posedge clk_sys);
		chk(32'(pci_clk_on), 32'(v));
	endtask
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Watchdog well beyond the expected run
	initial
	begin
		cyc(3000);
		n_errors++;
		tally_and_finish();
	end
	initial
	begin
		clk_sys = 1'b0;
		rst = 1'b1;
		voltage_select_strap = 1'b0;
		port1_overcurrent_in = 1'b0;
		port2_overcurrent_in = 1'b1;
		stop_allowed = 1'b0;
		usb_clk_stopped = 1'b0;
		wake = 3'h0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		n_errors = 0;
		samples_checked = 0;
		cyc(6);
		rst <= 1'b0;
		cyc(3);
		chk(32'(core_5v), 32'h1);
		voltage_select_strap <= 1'b1;
		cyc(3);
		chk(32'(core_5v), 32'h1);
		rd(core_voltage_select_off, d);
		chk(d & 32'h20, 32'h20);
		// Faults: port 1 active high, port 2 active low
		rd(irq_status_off, d);
		wr(irq_mask_off, 32'h2);
		port1_overcurrent_in <= 1'b1;
		cyc(3);
		chk(32'({port1_fault, port2_fault}), 32'h2);
		port2_overcurrent_in <= 1'b0;
		cyc(3);
		chk(32'({port1_fault, port2_fault}), 32'h3);
		chk(32'(irq), 32'h1);
		port1_overcurrent_in <= 1'b0;
		port2_overcurrent_in <= 1'b1;
		cyc(3);
		chk(32'({port1_fault, port2_fault}), 32'h0);
		rd(irq_status_off, d);
		chk(d & 32'h6, 32'h6);
		cyc(2);
		chk(32'(irq), 32'h0);
		// Masked event must not interrupt
		wr(irq_mask_off, 32'h0);
		port1_overcurrent_in <= 1'b1;
		cyc(3);
		chk(32'(irq), 32'h0);
		port1_overcurrent_in <= 1'b0;
		wr(core_voltage_select_off, 32'h0);
		cyc(2);
		chk(32'(core_5v), 32'h0);
		wr(core_voltage_select_off, 32'h20);
		cyc(2);
		chk(32'(core_5v), 32'h1);
		// One bit alone keeps the I/O cells on
		wr(power_clock_control_off, 32'h1);
		cyc(2);
		chk(32'(usb_io_off), 32'h0);
		// Firmware switches the I/O cells off before suspend
		wr(power_clock_control_off, 32'h3);
		cyc(2);
		chk(32'(usb_io_off), 32'h1);
		// Unmapped place ignores writes, reads zero
		wr(8'h7C, 32'hFFFF_FFFF);
		rd(8'h7C, d);
		chk(d, 32'h0);
		wr(host_controller_control_off, 32'hC0);
		cyc(2);
		chk(32'(usb_suspended), 32'h1);
		// USB clock may stop only now that the controller is suspended
		usb_clk_stopped <= 1'b1;
		rd(host_controller_control_off, d);
		chk(d, 32'hC0);
		// Latched straps, clock state, I/O off and suspend read back
		rd(state_off, d);
		chk(d, 32'h56);
		// Clock-run disabled: wake cannot restart the clock
		wr(power_clock_control_off, 32'h0);
		stop_allowed <= 1'b1;
		await_clk(1'b0);
		chk(32'(usb_io_off), 32'h0);
		wake <= 3'h1;
		cyc(1);
		wake <= 3'h0;
		cyc(20);
		chk(32'(pci_clk_on), 32'h0);
		stop_allowed <= 1'b0;
		await_clk(1'b1);
		// Without power saving the device keeps the clock running
		wr(power_clock_control_off, 32'h4);
		stop_allowed <= 1'b1;
		k = 0;
		for (int i = 0; i < 40; i++)
		begin
			@(posedge clk_sys);
			if (pci_clk_on !== 1'b1)
				k++;
		end
		chk(32'(k), 32'h0);
		stop_allowed <= 1'b0;
		wr(power_clock_control_off, 32'h14);
		// Let any stop begun under the old mode finish and restart
		cyc(10);
		// Every wake kind restarts a stopped clock
		for (int i = 0; i < 3; i++)
		begin
			stop_allowed <= 1'b1;
			await_clk(1'b0);
			wake <= 3'(1 << i);
			cyc(1);
			wake <= 3'h0;
			await_clk(1'b1);
			cyc(1);
			chk(32'(clk_restarted), 32'h1);
			stop_allowed <= 1'b0;
			cyc(4);
		end
		// Wake, clock-run and voltage events left their sticky bits
		rd(irq_status_off, d);
		chk(d & 32'h19, 32'h19);
		// Second reset: strap high selects 3.3V, port 1 strapped active low
		port1_overcurrent_in <= 1'b1;
		rst <= 1'b1;
		cyc(6);
		rst <= 1'b0;
		cyc(3);
		chk(32'(core_5v), 32'h0);
		chk(32'({port1_fault, port2_fault}), 32'h0);
		port1_overcurrent_in <= 1'b0;
		cyc(3);
		chk(32'({port1_fault, port2_fault}), 32'h2);
		tally_and_finish();
	end
endmodule
